// ==== common/fdcpp_cfg.svh ====
/*
  Constants of the floppy base / floppy-on-parallel configuration pair:
  index codes, reset values, write masks and field positions.
  Assumes it is included by bare name after the package is compiled.
*/
// Function
// - The floppy base register is touched only in configuration state with index 20H.
// - The base register picks one of 48 16-byte slots from 100H to 3F0H via bits 9..4.
// - With base bits 9 and 8 both zero the floppy controller is not decoded at all.
// - Decode needs host bits 15..10 zero and bit 3 zero; bits 2..0 pick the register.
// - Reserved bits ignore writes and read zero: base bits 1..0, routing bits 7..3.
// - Power-on reset loads the base register with 3CH, i.e. base 0F0H with decode off.
// - The routing register is reached only in configuration state with index 21H, reset 00H.
// - Routing code 00 lets the parallel mode bits decide and ignores the pin; 11 is reserved.
// - Code 01 with the pin low puts drive 0 on floppy pins and drive 1 on parallel pins.
// - Code 10 with the pin low puts both drives on the parallel port pins.
// - Clear select 0 clears the EPP timeout flag at the trailing edge of a status read.
// - Clear select 1 clears the EPP timeout flag only on a write of 1 to it.
`ifndef FDCPP_CFG_SVH
`define FDCPP_CFG_SVH

// Configuration index codes
`define FDCPP_IDX_BASE 8'h20
`define FDCPP_IDX_ROUTE 8'h21

// Power-on values
`define FDCPP_BASE_RST 8'h3C
`define FDCPP_ROUTE_RST 8'h00

// Writable bit masks, reserved bits cleared
`define FDCPP_BASE_WMASK 8'hFC
`define FDCPP_ROUTE_WMASK 8'h07

// Field positions
`define FDCPP_BASE_HI 7
`define FDCPP_BASE_LO 2
`define FDCPP_BASE_EN_HI 7
`define FDCPP_BASE_EN_LO 6
`define FDCPP_ROUTE_HI 1
`define FDCPP_ROUTE_LO 0
`define FDCPP_TOSEL_BIT 2

// Host address decode fields
`define FDCPP_ADDR_TOP_HI 15
`define FDCPP_ADDR_TOP_LO 10
`define FDCPP_ADDR_BLK_HI 9
`define FDCPP_ADDR_BLK_LO 4
`define FDCPP_ADDR_GAP_BIT 3
`define FDCPP_ADDR_REG_HI 2
`define FDCPP_ADDR_REG_LO 0
`define FDCPP_ADDR_TOP_ZERO 6'h00
`define FDCPP_BASE_EN_OFF 2'h0

`endif

// ==== common/fdcpp_pkg.sv ====
/*
  Types shared by the floppy configuration pair.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fdcpp_pkg;

  // Routing field codes of the floppy-on-parallel register
  typedef enum logic [1:0] {
    FDCPP_RT_MODEREG = 2'h0,
    FDCPP_RT_PIN_D1 = 2'h1,
    FDCPP_RT_PIN_BOTH = 2'h2,
    FDCPP_RT_RSVD = 2'h3
  } fdcpp_route_t;

endpackage

// ==== src/fdcpp_timeout.sv ====
/*
  EPP status timeout flag with selectable clear style.
  Assumes read strobe is a level that spans the host read cycle.
*/
`timescale 1ns/10ps
`include "fdcpp_cfg.svh"
module fdcpp_timeout (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Control
  input wire logic i_clr_by_write,
  input wire logic i_set,
  // Host access to the status register
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic i_wr_bit,
  // Flag
  output logic o_flag
);

  logic flag_q, flag_d;
  logic rd_q, rd_d;
  logic clr;

  // Clear source chosen by select bit; a new timeout beats any clear
  always_comb begin
    rd_d = i_rd;
    if (i_clr_by_write) begin
      clr = i_wr & i_wr_bit;
    end else begin
      clr = rd_q & ~i_rd;
    end
    flag_d = i_set | (flag_q & ~clr);
  end

  // Registers
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      flag_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      rd_q <= rd_d;
    end
  end

  assign o_flag = flag_q;

endmodule

// ==== src/fdcpp_top.sv ====
/*
  Floppy base address and floppy-on-parallel / EPP timeout select
  configuration registers, with the floppy I/O decoder, drive routing
  and the EPP timeout flag they steer.
  Assumes the configuration state machine and index register live
  outside and present their state as synchronous levels, and that
  host strobes are synchronous to i_clk_sys.
*/
`timescale 1ns/10ps
`include "fdcpp_cfg.svh"
module fdcpp_top (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Configuration access
  input wire logic i_cfg_active,
  input wire logic [7:0] i_config_index_register,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_wdata,
  output logic [7:0] o_cfg_rdata,
  output logic o_cfg_hit,
  // Host I/O decode
  input wire logic i_io_valid,
  input wire logic [15:0] i_io_addr,
  output logic o_floppy_controller_sel,
  output logic [2:0] o_floppy_controller_reg,
  output logic o_floppy_controller_en,
  // Drive routing
  input wire logic i_floppy_pp_routing,
  input wire logic i_pp_mode_drv0,
  input wire logic i_pp_mode_drv1,
  output logic o_drv0_on_parallel_port,
  output logic o_drv1_on_parallel_port,
  output logic o_parallel_port_normal,
  // EPP status timeout
  input wire logic i_epp_timeout_set,
  input wire logic i_epp_stat_rd,
  input wire logic i_epp_stat_wr,
  input wire logic i_epp_stat_wr_timeout,
  output logic o_epp_timeout
);

  logic [7:0] base_q, base_d;
  logic [7:0] route_q, route_d;
  logic [7:0] rdata_q, rdata_d;
  logic hit_q, hit_d;
  logic sel_base, sel_route;
  logic base_en;

  // Register select, only in configuration state
  always_comb begin
    sel_base = i_cfg_active && (i_config_index_register == `FDCPP_IDX_BASE);
    sel_route = i_cfg_active && (i_config_index_register == `FDCPP_IDX_ROUTE);
  end

  // Configuration register next values
  always_comb begin
    base_d = base_q;
    route_d = route_q;
    if (i_cfg_wr && sel_base) begin
      base_d = i_cfg_wdata & `FDCPP_BASE_WMASK;
    end
    if (i_cfg_wr && sel_route) begin
      route_d = i_cfg_wdata & `FDCPP_ROUTE_WMASK;
    end
  end

  // Read path; other indices answer zero and leave hit low
  always_comb begin
    rdata_d = 8'h00;
    hit_d = 1'b0;
    if (i_cfg_rd && sel_base) begin
      rdata_d = base_q;
      hit_d = 1'b1;
    end else if (i_cfg_rd && sel_route) begin
      rdata_d = route_q;
      hit_d = 1'b1;
    end
  end

  // Configuration registers
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      base_q <= `FDCPP_BASE_RST;
      route_q <= `FDCPP_ROUTE_RST;
      rdata_q <= 8'h00;
      hit_q <= 1'b0;
    end else begin
      base_q <= base_d;
      route_q <= route_d;
      rdata_q <= rdata_d;
      hit_q <= hit_d;
    end
  end

  assign o_cfg_rdata = rdata_q;
  assign o_cfg_hit = hit_q;

  // Floppy decode state
  logic sel_q, sel_d;
  logic [2:0] reg_q, reg_d;
  logic en_q, en_d;

  // Address compare; upper base bits both zero switch the block off
  always_comb begin
    base_en = base_q[`FDCPP_BASE_EN_HI:`FDCPP_BASE_EN_LO] != `FDCPP_BASE_EN_OFF;
    en_d = base_en;
    sel_d = i_io_valid && base_en
      && (i_io_addr[`FDCPP_ADDR_TOP_HI:`FDCPP_ADDR_TOP_LO] == `FDCPP_ADDR_TOP_ZERO)
      && !i_io_addr[`FDCPP_ADDR_GAP_BIT]
      && (i_io_addr[`FDCPP_ADDR_BLK_HI:`FDCPP_ADDR_BLK_LO]
          == base_q[`FDCPP_BASE_HI:`FDCPP_BASE_LO]);
    reg_d = sel_d ? i_io_addr[`FDCPP_ADDR_REG_HI:`FDCPP_ADDR_REG_LO] : 3'h0;
  end

  // Decode registers, one cycle behind the address
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sel_q <= 1'b0;
      reg_q <= 3'h0;
      en_q <= 1'b0;
    end else begin
      sel_q <= sel_d;
      reg_q <= reg_d;
      en_q <= en_d;
    end
  end

  assign o_floppy_controller_sel = sel_q;
  assign o_floppy_controller_reg = reg_q;
  assign o_floppy_controller_en = en_q;

  // Drive routing state
  fdcpp_pkg::fdcpp_route_t route_mode;
  logic d0_q, d0_d;
  logic d1_q, d1_d;
  logic ppn_q, ppn_d;

  // Routing choice; reserved code keeps everything on floppy pins
  always_comb begin
    route_mode = fdcpp_pkg::fdcpp_route_t'(route_q[`FDCPP_ROUTE_HI:`FDCPP_ROUTE_LO]);
    d0_d = 1'b0;
    d1_d = 1'b0;
    case (route_mode)
      fdcpp_pkg::FDCPP_RT_MODEREG: begin
        d0_d = i_pp_mode_drv0;
        d1_d = i_pp_mode_drv1;
      end
      fdcpp_pkg::FDCPP_RT_PIN_D1: begin
        d1_d = !i_floppy_pp_routing;
      end
      fdcpp_pkg::FDCPP_RT_PIN_BOTH: begin
        d0_d = !i_floppy_pp_routing;
        d1_d = !i_floppy_pp_routing;
      end
      default: begin
        d0_d = 1'b0;
        d1_d = 1'b0;
      end
    endcase
    ppn_d = !(d0_d || d1_d);
  end

  // Routing registers
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      d0_q <= 1'b0;
      d1_q <= 1'b0;
      ppn_q <= 1'b1;
    end else begin
      d0_q <= d0_d;
      d1_q <= d1_d;
      ppn_q <= ppn_d;
    end
  end

  assign o_drv0_on_parallel_port = d0_q;
  assign o_drv1_on_parallel_port = d1_q;
  assign o_parallel_port_normal = ppn_q;

  // EPP timeout flag, clear style from the select bit
  fdcpp_timeout u_timeout (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_clr_by_write(route_q[`FDCPP_TOSEL_BIT]),
    .i_set(i_epp_timeout_set),
    .i_rd(i_epp_stat_rd),
    .i_wr(i_epp_stat_wr),
    .i_wr_bit(i_epp_stat_wr_timeout),
    .o_flag(o_epp_timeout)
  );

  // Checks, all in the system clock domain
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);

  a_base_write_gate: assert property (
    !(i_cfg_wr && sel_base) |=> $stable(base_q))
    else $error("base register changed without a selected write");

  a_route_write_gate: assert property (
    !(i_cfg_wr && sel_route) |=> $stable(route_q))
    else $error("routing register changed without a selected write");

  // Reset value checked across the reset itself, so no disable here
  a_base_reset_value: assert property (disable iff (1'b0)
    !i_nrst |=> base_q == `FDCPP_BASE_RST && route_q == `FDCPP_ROUTE_RST)
    else $error("power-on values not loaded");

  a_base_reserved: assert property (
    (base_q & ~`FDCPP_BASE_WMASK) == 8'h00 && (route_q & ~`FDCPP_ROUTE_WMASK) == 8'h00)
    else $error("reserved bits are not zero");

  a_route_store: assert property (
    (i_cfg_wr && sel_route) |=> route_q == ($past(i_cfg_wdata) & `FDCPP_ROUTE_WMASK))
    else $error("routing write not stored");

  a_read_base: assert property (
    (i_cfg_rd && sel_base) |=> o_cfg_hit && o_cfg_rdata == $past(base_q))
    else $error("base read answer wrong");

  a_read_route: assert property (
    (i_cfg_rd && sel_route) |=> o_cfg_hit && o_cfg_rdata == $past(route_q))
    else $error("routing read answer wrong");

  a_read_refused: assert property (
    !(i_cfg_rd && (sel_base || sel_route)) |=> !o_cfg_hit && o_cfg_rdata == 8'h00)
    else $error("unselected read answered");

  a_base_store: assert property (
    (i_cfg_wr && sel_base) |=> base_q == ($past(i_cfg_wdata) & `FDCPP_BASE_WMASK))
    else $error("base write not stored");

  a_decode_match: assert property (
    o_floppy_controller_sel
    |-> $past(i_io_addr[`FDCPP_ADDR_BLK_HI:`FDCPP_ADDR_BLK_LO])
        == $past(base_q[`FDCPP_BASE_HI:`FDCPP_BASE_LO]))
    else $error("floppy select on wrong block");

  a_decode_off: assert property (
    ($past(base_q[`FDCPP_BASE_EN_HI:`FDCPP_BASE_EN_LO]) == `FDCPP_BASE_EN_OFF)
    |-> !o_floppy_controller_sel)
    else $error("floppy decoded while disabled");

  a_decode_enable: assert property (
    o_floppy_controller_en
    == ($past(base_q[`FDCPP_BASE_EN_HI:`FDCPP_BASE_EN_LO]) != `FDCPP_BASE_EN_OFF))
    else $error("floppy enable does not follow base bits");

  a_decode_upper: assert property (
    (i_io_valid && (i_io_addr[`FDCPP_ADDR_TOP_HI:`FDCPP_ADDR_TOP_LO] != `FDCPP_ADDR_TOP_ZERO
                    || i_io_addr[`FDCPP_ADDR_GAP_BIT]))
    |=> !o_floppy_controller_sel)
    else $error("floppy selected with bad upper or gap bits");

  // Register field is zero whenever the block is not selected
  a_decode_reg: assert property (
    o_floppy_controller_reg == (o_floppy_controller_sel
      ? $past(i_io_addr[`FDCPP_ADDR_REG_HI:`FDCPP_ADDR_REG_LO]) : 3'h0))
    else $error("floppy register field wrong");

  a_route_pin_d1: assert property (
    (route_mode == fdcpp_pkg::FDCPP_RT_PIN_D1 && !i_floppy_pp_routing)
    |=> !o_drv0_on_parallel_port && o_drv1_on_parallel_port)
    else $error("code 01 pin low routing wrong");

  a_route_pin_both: assert property (
    (route_mode == fdcpp_pkg::FDCPP_RT_PIN_BOTH && !i_floppy_pp_routing)
    |=> o_drv0_on_parallel_port && o_drv1_on_parallel_port)
    else $error("code 10 pin low routing wrong");

  a_route_pin_high: assert property (
    ((route_mode == fdcpp_pkg::FDCPP_RT_PIN_D1 || route_mode == fdcpp_pkg::FDCPP_RT_PIN_BOTH)
     && i_floppy_pp_routing)
    |=> !o_drv0_on_parallel_port && !o_drv1_on_parallel_port && o_parallel_port_normal)
    else $error("pin high did not keep drives on floppy pins");

  a_route_modereg: assert property (
    (route_mode == fdcpp_pkg::FDCPP_RT_MODEREG)
    |=> o_drv0_on_parallel_port == $past(i_pp_mode_drv0)
        && o_drv1_on_parallel_port == $past(i_pp_mode_drv1))
    else $error("mode register routing not followed");

  a_route_reserved: assert property (
    (route_mode == fdcpp_pkg::FDCPP_RT_RSVD)
    |=> !o_drv0_on_parallel_port && !o_drv1_on_parallel_port)
    else $error("reserved code moved a drive");

  a_normal_flag: assert property (
    o_parallel_port_normal == !(o_drv0_on_parallel_port || o_drv1_on_parallel_port))
    else $error("normal flag disagrees with drive routing");

  a_to_read_clear: assert property (
    (!route_q[`FDCPP_TOSEL_BIT] && o_epp_timeout && $fell(i_epp_stat_rd)
     && !i_epp_timeout_set)
    |=> !o_epp_timeout)
    else $error("timeout not cleared after status read");

  a_to_read_hold: assert property (
    (!route_q[`FDCPP_TOSEL_BIT] && o_epp_timeout && i_epp_stat_rd)
    |=> o_epp_timeout)
    else $error("timeout cleared before end of read");

  a_to_read_keep: assert property (
    (route_q[`FDCPP_TOSEL_BIT] && o_epp_timeout
     && !(i_epp_stat_wr && i_epp_stat_wr_timeout))
    |=> o_epp_timeout)
    else $error("timeout lost without a write of one");

  a_to_write_clear: assert property (
    (route_q[`FDCPP_TOSEL_BIT] && i_epp_stat_wr && i_epp_stat_wr_timeout
     && !i_epp_timeout_set)
    |=> !o_epp_timeout)
    else $error("timeout not cleared by a write of one");

  a_to_set_wins: assert property (
    i_epp_timeout_set |=> o_epp_timeout)
    else $error("timeout event lost");

  c_base_write: cover property (i_cfg_wr && sel_base
    ##1 base_q[`FDCPP_BASE_EN_HI:`FDCPP_BASE_EN_LO] == `FDCPP_BASE_EN_OFF);
  c_floppy_hit: cover property (o_floppy_controller_sel);
  c_route_both: cover property (o_drv0_on_parallel_port && o_drv1_on_parallel_port);
  c_route_d1: cover property (!o_drv0_on_parallel_port && o_drv1_on_parallel_port);
  c_to_write_clear: cover property (route_q[`FDCPP_TOSEL_BIT] && o_epp_timeout
    ##1 !o_epp_timeout);

endmodule

// ==== test/fdcpp_host_model.sv ====
/*
  Host model issuing configuration data cycles toward the block.
  Assumes the bench clock and that tasks are called from the bench.
*/
`timescale 1ns/10ps
module fdcpp_host_model (
  // Clock
  input wire logic i_clk_sys,
  // Configuration cycle
  output logic o_cfg_active,
  output logic [7:0] o_index,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata,
  // Answer
  input wire logic [7:0] i_rdata,
  input wire logic i_hit
);
  // Idle bus at time zero
  initial begin
    o_cfg_active = 1'b0;
    o_index = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end

  // One write pulse; base writes keep the two low bits clear
  task automatic cfg_write(input logic act, input logic [7:0] idx, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_cfg_active = act;
    o_index = idx;
    o_wdata = (idx == 8'h20) ? (d & 8'hFC) : d;
    o_wr = 1'b1;
    @(negedge i_clk_sys);
    o_wr = 1'b0;
    o_wdata = ~o_wdata; // Released data shows no stale byte
    o_cfg_active = 1'b0;
  endtask

  // One read pulse; data taken where it stands
  task automatic cfg_read(input logic act, input logic [7:0] idx, output logic [7:0] d,
                          output logic h);
    @(negedge i_clk_sys);
    o_cfg_active = act;
    o_index = idx;
    o_rd = 1'b1;
    @(negedge i_clk_sys);
    o_rd = 1'b0;
    d = i_rdata;
    h = i_hit;
    o_cfg_active = 1'b0;
  endtask
endmodule

// ==== test/fdcpp_top_tb.sv ====
/*
  Self-checking bench for the floppy configuration pair.
  Assumes the host model drives the configuration cycles.
*/
`timescale 1ns/10ps
module fdcpp_top_tb;
  logic clk = 1'b0, nrst = 1'b0, act, wr, rd, hit, iov = 1'b0, pin = 1'b1, m0 = 1'b0;
  logic m1 = 1'b0, tset = 1'b0, srd = 1'b0, swr = 1'b0, swb = 1'b0, tflag, sel, en;
  logic d0, d1, nrm, h, e0, e1;
  logic [7:0] idx, wd, rdat, d;
  logic [15:0] ioa = 16'h0000;
  logic [2:0] rg;
  int failures = 0, check_count = 0;

  // Clock
  initial begin
    forever #5 clk = ~clk;
  end

  fdcpp_host_model host (.i_clk_sys(clk), .o_cfg_active(act), .o_index(idx), .o_wr(wr),
    .o_rd(rd), .o_wdata(wd), .i_rdata(rdat), .i_hit(hit));

  fdcpp_top dut (.i_clk_sys(clk), .i_nrst(nrst), .i_cfg_active(act),
    .i_config_index_register(idx), .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_wdata(wd),
    .o_cfg_rdata(rdat), .o_cfg_hit(hit), .i_io_valid(iov), .i_io_addr(ioa),
    .o_floppy_controller_sel(sel), .o_floppy_controller_reg(rg),
    .o_floppy_controller_en(en), .i_floppy_pp_routing(pin), .i_pp_mode_drv0(m0),
    .i_pp_mode_drv1(m1), .o_drv0_on_parallel_port(d0), .o_drv1_on_parallel_port(d1),
    .o_parallel_port_normal(nrm), .i_epp_timeout_set(tset), .i_epp_stat_rd(srd),
    .i_epp_stat_wr(swr), .i_epp_stat_wr_timeout(swb), .o_epp_timeout(tflag));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string s);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Read with expected byte and hit flag
  task automatic rdchk(input logic a, input logic [7:0] i, input logic [7:0] exp,
                       input logic eh);
    host.cfg_read(a, i, d, h);
    chk({h, d[6:0]}, {eh, exp[6:0]}, "cfg read");
    chk({7'h00, d[7]}, {7'h00, exp[7]}, "cfg read msb");
  endtask

  // One sampled address, then enable/select/register compared
  task automatic io(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clk);
    iov = 1'b1;
    ioa = a;
    @(negedge clk);
    iov = 1'b0;
    ioa = ~a;
    chk({3'h0, en, sel, rg}, exp, "decode");
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard
  initial begin
    #200us;
    failures++;
    finish_test();
  end

  initial begin
    tick(8);
    nrst = 1'b1;
    rdchk(1, 8'h20, 8'h3C, 1);
    rdchk(1, 8'h21, 8'h00, 1);
    host.cfg_write(1, 8'h21, 8'hFF);
    rdchk(1, 8'h21, 8'h07, 1);
    // Refused writes leave contents alone
    host.cfg_write(0, 8'h20, 8'h40);
    host.cfg_write(1, 8'h22, 8'h40);
    host.cfg_write(0, 8'h21, 8'h00);
    rdchk(1, 8'h20, 8'h3C, 1);
    rdchk(1, 8'h21, 8'h07, 1);
    rdchk(0, 8'h20, 8'h00, 0);
    rdchk(1, 8'h22, 8'h00, 0);
    // Decoder at base 3F0 and 100
    host.cfg_write(1, 8'h20, 8'hFC);
    rdchk(1, 8'h20, 8'hFC, 1);
    io(16'h03F5, 8'h1D);
    io(16'h03F8, 8'h10);
    io(16'h07F5, 8'h10);
    io(16'h03E5, 8'h10);
    host.cfg_write(1, 8'h20, 8'h40);
    io(16'h0107, 8'h1F);
    io(16'h0100, 8'h18);
    host.cfg_write(1, 8'h20, 8'h3C);
    io(16'h00F2, 8'h00);
    // Every routing code against pin and mode bits
    for (int c = 0; c < 4; c++) begin
      host.cfg_write(1, 8'h21, c[7:0]);
      for (int k = 0; k < 8; k++) begin
        @(negedge clk);
        m0 = k[0];
        m1 = k[1];
        pin = k[2];
        @(negedge clk);
        e0 = (c == 0) ? k[0] : (c == 2 && !k[2]);
        e1 = (c == 0) ? k[1] : ((c == 1 || c == 2) && !k[2]);
        chk({5'h00, nrm, d1, d0}, {5'h00, ~(e0 | e1), e1, e0}, "route");
      end
    end
    // Timeout cleared by end of status read
    host.cfg_write(1, 8'h21, 8'h00);
    tset = 1'b1;
    tick(1);
    tset = 1'b0;
    srd = 1'b1;
    tick(1);
    chk({7'h00, tflag}, 8'h01, "flag set");
    tick(1);
    chk({7'h00, tflag}, 8'h01, "flag kept in read");
    srd = 1'b0;
    tick(2);
    chk({7'h00, tflag}, 8'h00, "flag read clear");
    // Timeout cleared only by writing one
    host.cfg_write(1, 8'h21, 8'h04);
    tset = 1'b1;
    tick(1);
    tset = 1'b0;
    srd = 1'b1;
    tick(1);
    srd = 1'b0;
    swr = 1'b1;
    tick(1);
    swr = 1'b0;
    tick(2);
    chk({7'h00, tflag}, 8'h01, "flag kept");
    swr = 1'b1;
    swb = 1'b1;
    tick(1);
    swr = 1'b0;
    swb = 1'b0;
    tick(2);
    chk({7'h00, tflag}, 8'h00, "flag write clear");
    finish_test();
  end
endmodule
